// >>> inc/ssp_consts.vh
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define SSP_IDX_BUFFER 6'h2b
`define SSP_IDX_CONTROL 6'h31
`define SSP_IDX_STATUS_HI 6'h32
`define SSP_IDX_CTRL 8'h31
`define SSP_IDX_STAT 8'h32
`define SSP_IDX_BUF 8'h2b

// ----------------------------------------------------------------------
// Control register fields and reset value.
// ----------------------------------------------------------------------
`define SSP_CTRL_START 7
`define SSP_CTRL_FORCE 6
`define SSP_CTRL_MODE_HI 5
`define SSP_CTRL_MODE_LO 4
`define SSP_CTRL_ORDER 3
`define SSP_CTRL_CLK_HI 2
`define SSP_CTRL_CLK_LO 0
`define SSP_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Status register fields and reset value.
// ----------------------------------------------------------------------
`define SSP_STAT_ACTIVE 7
`define SSP_STAT_PARTIAL 6
`define SSP_STAT_TX_EMPTY 5
`define SSP_STAT_RX_FULL 4
`define SSP_STAT_TX_ERR 3
`define SSP_STAT_RX_ERR 2
`define SSP_STAT_RESET 8'h20
`define SSP_RXBUF_RESET 8'h00

// ----------------------------------------------------------------------
// Transfer modes.
// ----------------------------------------------------------------------
`define SSP_MODE_TX 2'h0
`define SSP_MODE_RX 2'h1
`define SSP_MODE_TXRX 2'h2

// ----------------------------------------------------------------------
// Serial clock codes and half periods, less one, in base ticks.
// ----------------------------------------------------------------------
`define SSP_CLK_EXT 3'h7
`define SSP_HALF_4096 12'h7ff
`define SSP_HALF_256 12'h07f
`define SSP_HALF_128 12'h03f
`define SSP_HALF_64 12'h01f
`define SSP_HALF_32 12'h00f
`define SSP_HALF_16 12'h007
`define SSP_HALF_8 12'h003
`define SSP_HALF_LF16 12'h007

// ----------------------------------------------------------------------
// Least external clock phase, in high-frequency clock periods.
// ----------------------------------------------------------------------
`define SSP_EXT_MIN_PHASE_FC 4
`define SSP_BYTE_BITS 4'h8

`endif

// >>> hdl/ssp_serial_port.v
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "ssp_consts.vh"

// ----------------------------------------------------------------------
// Timing overview.
// ----------------------------------------------------------------------
// The bus side answers every access in its access phase with no wait
// states while the clock enable is high. Read data is captured in the
// setup cycle, so a status read reflects the state one cycle before the
// access edge. Side effects of an access, such as clearing the receive
// full flag, take place at the access edge itself.
//
// With an internal clock the pin clock is made from a free-running
// half-period counter. A byte starts only at a half-period tick with the
// clock pin high, so a released wait restarts the clock in less than one
// serial clock period. Between bytes the clock rests high while the
// transmit buffer is empty (transmit modes) or the receive buffer is
// full (receive modes).
//
// With the external clock the pin level is taken through two flip-flops
// and a third one that remembers the previous level. Edges are found
// only on the synchronised samples, so an edge is seen two to three
// cycles late. Each phase of the external clock must therefore last at
// least four fast clock periods, or an edge may be lost.
//
// Each falling edge puts the next bit on the serial output; each rising
// edge samples the serial input. The eighth rising edge closes the byte,
// moves it to the receive buffer in receive modes and pulses the
// transfer interrupt for one cycle.
//
// A hardware event that sets a flag wins over a software clear in the
// same cycle, so no event is ever lost to a racing write. Force stop
// overrides everything and returns the engine to its reset state, except
// for the mode, order and clock fields, which keep their values.
//
// An external transfer that starts with no transmit data sets the
// underrun flag and keeps the serial output high for the whole byte. A
// byte completed while the receive buffer is still full, or while the
// overrun flag is set, is dropped and sets the overrun flag.
//
// The reserved mode code and the reserved slow-mode clock codes are not
// blocked; they fall into the nearest defined behaviour.

module ssp_serial_port #(
  parameter LF_HALF = 12'h007
) (
  // System.
  input wire MCLK,
  input wire RESET,
  input wire CE,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // Clock source selection from the timebase and power mode.
  input wire TIMEBASE_DIVIDER_SELECT,
  input wire SLOW_MODE,
  input wire LOW_FREQ_TICK,
  // Serial pins.
  input wire SERIAL_IN_PIN,
  output reg SERIAL_OUT_PIN,
  input wire SERIAL_CLOCK_IN,
  output reg SERIAL_CLOCK_OUT,
  output wire SERIAL_CLOCK_OE,
  // Byte event.
  output reg TRANSFER_INTERRUPT
);

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  reg transfer_start;
  reg [1:0] transfer_mode_select;
  reg bit_order_select;
  reg [2:0] serial_clock_select;
  reg transfer_active;
  reg tx_buffer_empty;
  reg rx_buffer_full;
  reg tx_underrun_error;
  reg rx_overrun_error;
  reg [7:0] receive_buffer;
  reg [7:0] transmit_buffer;
  reg [7:0] shift_reg;
  reg [3:0] bit_count;
  reg [11:0] half_count;
  reg clk_sync1;
  reg clk_sync2;
  reg clk_sync3;

  // --------------------------------------------------------------------
  // Bus decode.
  // --------------------------------------------------------------------
  wire word_ok = (PADDR[1:0] == 2'h0);
  wire hit_buf = word_ok && (PADDR[7:2] == `SSP_IDX_BUFFER);
  wire hit_ctrl = word_ok && (PADDR[7:2] == `SSP_IDX_CONTROL);
  wire hit_stat = word_ok && (PADDR[7:2] == `SSP_IDX_STATUS_HI);
  wire mapped = hit_buf || hit_ctrl || hit_stat;
  wire access = PSEL && PENABLE && CE;
  wire wr_ctrl = access && PWRITE && hit_ctrl;
  wire wr_stat = access && PWRITE && hit_stat;
  wire wr_tx = access && PWRITE && hit_buf;
  wire rd_rx = access && !PWRITE && hit_buf;
  wire force_stop = wr_ctrl && PWDATA[`SSP_CTRL_FORCE];

  // The slave never inserts wait states; a frozen block holds the access.
  assign PREADY = CE;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // --------------------------------------------------------------------
  // Derived conditions.
  // --------------------------------------------------------------------
  wire ext_clk = (serial_clock_select == `SSP_CLK_EXT);
  wire use_tx = (transfer_mode_select != `SSP_MODE_RX);
  wire use_rx = (transfer_mode_select != `SSP_MODE_TX);
  wire partial_clock_count = (bit_count != 4'h0) && (bit_count != `SSP_BYTE_BITS);
  wire slow_src = TIMEBASE_DIVIDER_SELECT || SLOW_MODE;
  wire [7:0] status_word = {transfer_active, partial_clock_count, tx_buffer_empty,
    rx_buffer_full, tx_underrun_error, rx_overrun_error, 2'h0};

  // The clock pin is driven only with an internal clock source.
  assign SERIAL_CLOCK_OE = !ext_clk;

  // Half period, less one, for the selected internal clock.
  reg [11:0] half_limit;
  always @* begin
    case (serial_clock_select)
      3'h0: half_limit = slow_src ? LF_HALF : `SSP_HALF_4096;
      3'h1: half_limit = `SSP_HALF_256;
      3'h2: half_limit = `SSP_HALF_128;
      3'h3: half_limit = `SSP_HALF_64;
      3'h4: half_limit = `SSP_HALF_32;
      3'h5: half_limit = `SSP_HALF_16;
      3'h6: half_limit = `SSP_HALF_8;
      default: half_limit = `SSP_HALF_8;
    endcase
  end

  // Base tick: the slow clock strobe for the slow source, every cycle otherwise.
  wire base_tick = (serial_clock_select == 3'h0 && slow_src) ? LOW_FREQ_TICK : 1'b1;
  wire half_tick = base_tick && (half_count >= half_limit);

  // Data service needed before the next byte may start.
  wire tx_ready = !use_tx || !tx_buffer_empty;
  wire rx_ready = !use_rx || !rx_buffer_full;
  wire mid_byte = (bit_count != 4'h0) && (bit_count != `SSP_BYTE_BITS);
  wire may_begin = (bit_count == 4'h0) && transfer_start;

  // External edges, seen only on synchronised samples.
  wire ext_fall = clk_sync3 && !clk_sync2;
  wire ext_rise = !clk_sync3 && clk_sync2;

  // Internal clock stops high while software has not serviced the buffers.
  wire int_fall = !ext_clk && half_tick && SERIAL_CLOCK_OUT &&
    (mid_byte || (may_begin && tx_ready && rx_ready));
  wire int_rise = !ext_clk && half_tick && !SERIAL_CLOCK_OUT;

  wire fall_ev = ext_clk ? (ext_fall && (mid_byte || may_begin)) : int_fall;
  wire rise_ev = (ext_clk ? ext_rise : int_rise) && (bit_count != 4'h0);
  wire byte_done = rise_ev && (bit_count == `SSP_BYTE_BITS);

  // Next value of the shift register on a sampling edge.
  wire [7:0] next_shift = bit_order_select ? {SERIAL_IN_PIN, shift_reg[7:1]} :
    {shift_reg[6:0], SERIAL_IN_PIN};

  // --------------------------------------------------------------------
  // External clock synchroniser.
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      clk_sync1 <= 1'b1;
      clk_sync2 <= 1'b1;
      clk_sync3 <= 1'b1;
    end else if (CE) begin
      clk_sync1 <= SERIAL_CLOCK_IN;
      clk_sync2 <= clk_sync1;
      clk_sync3 <= clk_sync2;
    end
  end

  // --------------------------------------------------------------------
  // Half-period counter; it runs freely so a restart waits under a period.
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      half_count <= 12'h000;
    end else if (CE) begin
      if (half_tick) begin
        half_count <= 12'h000;
      end else if (base_tick) begin
        half_count <= half_count + 12'h001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control register.
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      transfer_start <= 1'b0;
      transfer_mode_select <= 2'h0;
      bit_order_select <= 1'b0;
      serial_clock_select <= 3'h0;
    end else if (CE) begin
      if (force_stop) begin
        transfer_start <= 1'b0;
      end else if (wr_ctrl) begin
        transfer_start <= PWDATA[`SSP_CTRL_START];
        transfer_mode_select <= PWDATA[`SSP_CTRL_MODE_HI:`SSP_CTRL_MODE_LO];
        bit_order_select <= PWDATA[`SSP_CTRL_ORDER];
        serial_clock_select <= PWDATA[`SSP_CTRL_CLK_HI:`SSP_CTRL_CLK_LO];
      end
    end
  end

  // --------------------------------------------------------------------
  // Transfer engine, buffers and status flags.
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      transfer_active <= 1'b0;
      tx_buffer_empty <= 1'b1;
      rx_buffer_full <= 1'b0;
      tx_underrun_error <= 1'b0;
      rx_overrun_error <= 1'b0;
      receive_buffer <= `SSP_RXBUF_RESET;
      transmit_buffer <= 8'h00;
      shift_reg <= 8'h00;
      bit_count <= 4'h0;
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_CLOCK_OUT <= 1'b1;
      TRANSFER_INTERRUPT <= 1'b0;
    end else if (CE) begin
      TRANSFER_INTERRUPT <= 1'b0;
      if (force_stop) begin
        transfer_active <= 1'b0;
        tx_buffer_empty <= 1'b1;
        rx_buffer_full <= 1'b0;
        tx_underrun_error <= 1'b0;
        rx_overrun_error <= 1'b0;
        receive_buffer <= `SSP_RXBUF_RESET;
        transmit_buffer <= 8'h00;
        shift_reg <= 8'h00;
        bit_count <= 4'h0;
        SERIAL_OUT_PIN <= 1'b1;
        SERIAL_CLOCK_OUT <= 1'b1;
      end else begin
        // Software side; hardware sets further down take precedence.
        if (wr_tx && tx_buffer_empty) begin
          transmit_buffer <= PWDATA[7:0];
          tx_buffer_empty <= 1'b0;
        end
        if (rd_rx) begin
          rx_buffer_full <= 1'b0;
        end
        if (wr_stat && !PWDATA[`SSP_STAT_TX_ERR]) begin
          tx_underrun_error <= 1'b0;
        end
        if (wr_stat && !PWDATA[`SSP_STAT_RX_ERR]) begin
          rx_overrun_error <= 1'b0;
        end
        // Clock pin follows the internal edges.
        if (int_fall) begin
          SERIAL_CLOCK_OUT <= 1'b0;
        end else if (int_rise) begin
          SERIAL_CLOCK_OUT <= 1'b1;
        end
        // Falling edge: start a byte if needed and put out the next bit.
        if (fall_ev) begin
          transfer_active <= 1'b1;
          bit_count <= bit_count + 4'h1;
          if (bit_count == 4'h0) begin
            if (use_tx && !tx_buffer_empty) begin
              shift_reg <= transmit_buffer;
              tx_buffer_empty <= 1'b1;
              SERIAL_OUT_PIN <= bit_order_select ? transmit_buffer[0] :
                transmit_buffer[7];
            end else begin
              if (use_tx) begin
                tx_underrun_error <= 1'b1;
              end
              SERIAL_OUT_PIN <= 1'b1;
            end
          end else if (use_tx && !tx_underrun_error) begin
            SERIAL_OUT_PIN <= bit_order_select ? shift_reg[0] : shift_reg[7];
          end else begin
            SERIAL_OUT_PIN <= 1'b1;
          end
        end
        // Rising edge: sample the input; the eighth one closes the byte.
        if (rise_ev) begin
          shift_reg <= next_shift;
          if (byte_done) begin
            bit_count <= 4'h0;
            TRANSFER_INTERRUPT <= 1'b1;
            if (use_rx) begin
              if (rx_buffer_full || rx_overrun_error) begin
                rx_overrun_error <= 1'b1;
              end else begin
                receive_buffer <= next_shift;
                rx_buffer_full <= 1'b1;
              end
            end
          end
        end
        // Idle between bytes with start cleared ends the transfer.
        if (!transfer_start && bit_count == 4'h0 && !fall_ev) begin
          transfer_active <= 1'b0;
          SERIAL_OUT_PIN <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data, captured in the setup phase.
  // --------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
    end else if (CE) begin
      if (PSEL && !PENABLE && !PWRITE) begin
        if (hit_buf) begin
          PRDATA <= {24'h000000, receive_buffer};
        end else if (hit_ctrl) begin
          PRDATA <= {24'h000000, transfer_start, 1'b0, transfer_mode_select,
            bit_order_select, serial_clock_select};
        end else if (hit_stat) begin
          PRDATA <= {24'h000000, status_word};
        end else begin
          PRDATA <= 32'h00000000;
        end
      end
    end
  end

endmodule

// >>> testbench/ssp_serial_port_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks for the serial port.
// ----------------------------------------
module ssp_serial_port_assertions (
  // System.
  input wire MCLK,
  input wire RESET,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  // Serial pins and event.
  input wire SERIAL_OUT_PIN,
  input wire SERIAL_CLOCK_OUT,
  input wire SERIAL_CLOCK_OE,
  input wire TRANSFER_INTERRUPT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  chk_reset_idle: assert property ($fell(RESET) |->
    SERIAL_CLOCK_OUT && SERIAL_OUT_PIN && SERIAL_CLOCK_OE) else $error("pins busy after reset");
  chk_out_on_fall: assert property ($fell(SERIAL_OUT_PIN) && SERIAL_CLOCK_OE |->
    !SERIAL_CLOCK_OUT && $past(SERIAL_CLOCK_OUT, 2)) else $error("data moved off a falling edge");
  chk_int_pulse: assert property (TRANSFER_INTERRUPT |=> !TRANSFER_INTERRUPT)
    else $error("interrupt longer than one cycle");
  chk_int_after_rise: assert property (TRANSFER_INTERRUPT && SERIAL_CLOCK_OE |->
    SERIAL_CLOCK_OUT && !$past(SERIAL_CLOCK_OUT)) else $error("interrupt not after last rise");
  chk_low_width: assert property ($fell(SERIAL_CLOCK_OUT) |-> (!SERIAL_CLOCK_OUT)[*4])
    else $error("clock low phase too short");
  chk_high_width: assert property ($rose(SERIAL_CLOCK_OUT) |-> SERIAL_CLOCK_OUT[*4])
    else $error("clock high phase too short");
  chk_unmapped_err: assert property (PSEL && PENABLE |-> PSLVERR ==
    !(PADDR == 8'hac || PADDR == 8'hc4 || PADDR == 8'hc8)) else $error("slave error wrong");
  chk_oe_by_write: assert property ($changed(SERIAL_CLOCK_OE) |-> $past(RESET) ||
    $past(PSEL && PENABLE && PWRITE && PADDR == 8'hc4)) else $error("pin drive changed alone");
  chk_status_pad: assert property (PSEL && PENABLE && !PWRITE && PADDR == 8'hc8 |->
    PRDATA[1:0] == 2'h0 && PRDATA[31:8] == 24'h0) else $error("status spare bits set");
endmodule

bind ssp_serial_port ssp_serial_port_assertions i_chk (.MCLK(MCLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
  .SERIAL_CLOCK_OE(SERIAL_CLOCK_OE), .TRANSFER_INTERRUPT(TRANSFER_INTERRUPT));

// >>> testbench/ssp_peer_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side serial device with clock bursts.
// ----------------------------------------
module ssp_peer_model #(
  parameter int HALF = 8
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Device side of the pins.
  input wire clock_oe,
  input wire clock_drv,
  input wire data_from_dev,
  // Control and results.
  input wire [7:0] send_byte,
  input wire ext_go,
  output wire clock_wire,
  output logic data_to_dev,
  output logic [7:0] got_byte,
  output wire ext_busy
);
  logic ext_clk;
  logic last_clk;
  logic [2:0] bit_n;
  logic [4:0] ph;
  int tmr;
  // When the device does not drive the pin, it follows the model's own clock, which idles high.
  assign clock_wire = clock_oe ? clock_drv : ext_clk;
  assign ext_busy = (ph != 5'h0);
  // Eight pulses whose phases last HALF fast periods, four or more.
  always @(posedge mclk) begin
    if (rst) begin
      ext_clk <= 1'b1;
      ph <= 5'h0;
    end else if (ph == 5'h0) begin
      if (ext_go) begin
        ext_clk <= 1'b0;
        ph <= 5'd15;
        tmr <= HALF - 1;
      end
    end else if (tmr == 0) begin
      ext_clk <= ~ext_clk;
      ph <= ph - 5'h1;
      tmr <= HALF - 1;
    end else begin
      tmr <= tmr - 1;
    end
  end
  // Sends MSB first on falling edges and captures on rising edges.
  always @(posedge mclk) begin
    last_clk <= clock_wire;
    if (rst) begin
      bit_n <= 3'h0;
      data_to_dev <= 1'b1;
    end else if (last_clk && !clock_wire) begin
      data_to_dev <= send_byte[3'h7 - bit_n];
    end else if (!last_clk && clock_wire) begin
      got_byte <= {got_byte[6:0], data_from_dev};
      bit_n <= bit_n + 3'h1;
    end
  end
endmodule

// >>> testbench/ssp_serial_port_test.sv
`timescale 1ns/1ps
`include "ssp_consts.vh"
// ----------------------------------------
// Register-level tests of the serial port.
// ----------------------------------------
module ssp_serial_port_test;
  localparam logic [7:0] A_BUF = `SSP_IDX_BUF << 2;
  localparam logic [7:0] A_CTRL = `SSP_IDX_CTRL << 2;
  localparam logic [7:0] A_STAT = `SSP_IDX_STAT << 2;
  logic MCLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic tds = 1'b0, slow = 1'b0, lft = 1'b0, ext_go = 1'b0, peer_rst = 1'b1;
  wire [31:0] PRDATA;
  wire [7:0] peer_got;
  wire PREADY, PSLVERR, so, sco, scoe, tint, sck, si, ext_busy;
  int n_mismatch = 0, comparisons = 0, cycles = 0, lft_cnt = 0, n, m, want;
  logic [1:0] mode;
  logic [2:0] code;
  logic order;
  ssp_serial_port i_dut (.MCLK(MCLK), .RESET(RESET), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIMEBASE_DIVIDER_SELECT(tds), .SLOW_MODE(slow), .LOW_FREQ_TICK(lft),
    .SERIAL_IN_PIN(si), .SERIAL_OUT_PIN(so), .SERIAL_CLOCK_IN(sck), .SERIAL_CLOCK_OUT(sco),
    .SERIAL_CLOCK_OE(scoe), .TRANSFER_INTERRUPT(tint));
  ssp_peer_model #(.HALF(8)) i_peer (.mclk(MCLK), .rst(peer_rst), .clock_oe(scoe),
    .clock_drv(sco), .data_from_dev(so), .send_byte(8'ha6), .ext_go(ext_go),
    .clock_wire(sck), .data_to_dev(si), .got_byte(peer_got), .ext_busy(ext_busy));
  // Clock, a slow tick every ten cycles, and the hang limit.
  always #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    lft_cnt <= (lft_cnt == 9) ? 0 : lft_cnt + 1;
    lft <= (lft_cnt == 9);
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("MISMATCH at %0t ns: run hung", $time);
      close_out();
    end
  end
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
  endfunction
  task close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access held until pready is seen high.
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    int g;
    g = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && g < 20) begin
      g++;
      @(posedge MCLK);
    end
    if (g == 20) chk(16'h0, 16'h1);
    q = PRDATA[7:0];
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(a, 1'b1, d, q);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    apb(a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask
  task wait_int;
    n = 0;
    while (tint !== 1'b1 && n < 3000) begin
      @(posedge MCLK);
      n++;
    end
    chk(n < 3000, 1);
  endtask
  task ext_byte(input bit finish);
    ext_go <= 1'b1;
    @(posedge MCLK);
    ext_go <= 1'b0;
    n = 0;
    do @(posedge MCLK); while (finish && ext_busy && ++n < 400);
    repeat (6) @(posedge MCLK);
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    RESET <= 1'b0;
    peer_rst <= 1'b0;
    rdc(A_CTRL, 8'h00);
    rdc(A_STAT, 8'h20);
    rdc(A_BUF, 8'h00);
    rdc(8'h10, 8'h00);
    $display("test reset values done");
    // Every mode, both bit orders in full-duplex mode; settings change only while idle.
    for (int i = 0; i < 4; i++) begin
      mode = (i == 3) ? `SSP_MODE_TXRX : i[1:0];
      order = i[0];
      if (mode != `SSP_MODE_RX) begin
        wr(A_BUF, 8'h3c);
        wr(A_BUF, 8'hff);
        rdc(A_STAT, 8'h00);
      end
      wr(A_CTRL, {2'b10, mode, order, 3'h6});
      wait_int();
      rdc(A_STAT, (mode == `SSP_MODE_TX) ? 8'ha0 : 8'hb0);
      repeat (40) @(posedge MCLK);
      chk(sco, 1);
      if (mode != `SSP_MODE_TX) rdc(A_BUF, order ? rev8(8'ha6) : 8'ha6);
      if (mode != `SSP_MODE_RX) chk(peer_got, order ? rev8(8'h3c) : 8'h3c);
      if (mode != `SSP_MODE_RX) wr(A_BUF, 8'h5a);
      m = 0;
      while (sco !== 1'b0 && m < 40) begin
        @(posedge MCLK);
        m++;
      end
      chk(m <= 9, 1);
      wr(A_CTRL, {2'b00, mode, order, 3'h6});
      wait_int();
      repeat (10) @(posedge MCLK);
      rdc(A_STAT, (mode == `SSP_MODE_TX) ? 8'h20 : 8'h30);
      chk(so, 1);
      if (mode != `SSP_MODE_RX) chk(peer_got, order ? rev8(8'h5a) : 8'h5a);
      if (mode != `SSP_MODE_TX) rdc(A_BUF, order ? rev8(8'ha6) : 8'ha6);
    end
    $display("test internal clock modes done");
    wr(A_CTRL, 8'h87);
    ext_byte(1);
    rdc(A_STAT, 8'ha8);
    chk(peer_got, 8'hff);
    wr(A_STAT, 8'h08);
    rdc(A_STAT, 8'ha8);
    wr(A_CTRL, 8'h07);
    rdc(A_STAT, 8'h28);
    wr(A_STAT, 8'h00);
    rdc(A_STAT, 8'h20);
    wr(A_CTRL, 8'h97);
    ext_byte(1);
    ext_byte(1);
    rdc(A_STAT, 8'hb4);
    rdc(A_BUF, 8'ha6);
    ext_byte(0);
    repeat (24) @(posedge MCLK);
    wr(A_CTRL, 8'h57);
    rdc(A_CTRL, 8'h17);
    repeat (150) @(posedge MCLK);
    rdc(A_STAT, 8'h20);
    rdc(A_BUF, 8'h00);
    $display("test external clock errors done");
    for (int i = 0; i < 9; i++) begin
      code = (i < 7) ? i[2:0] : 3'h0;
      want = (i == 0) ? 2048 : (i < 7) ? (128 >> (i - 1)) : 80;
      tds <= (i == 7);
      slow <= (i == 8);
      wr(A_CTRL, {5'h12, code});
      n = 0;
      while (sco !== 1'b0 && n < 5000) begin
        @(posedge MCLK);
        n++;
      end
      m = 0;
      while (sco === 1'b0 && m < 5000) begin
        @(posedge MCLK);
        m++;
      end
      chk(m[15:0], want[15:0]);
      wr(A_CTRL, {5'h0a, code});
    end
    $display("test clock rates done");
    close_out();
  end
endmodule
